// file: verilog/spi_slave_front.sv
// Purpose: serial slave front end: opcode, address and data framing, read data shift-out
// Assumes: link logic runs on SCK_IN, system logic on CLK_IN; SCK at most 40 MHz
// Notes: chip select high clears the frame state asynchronously; RESET_IN also clears
//        link-side holding flops asynchronously, with constants only
`timescale 1ns/1ps
`default_nettype none
module spi_slave_front
    import spi_front_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic SCK_IN,
    input wire logic CS_N_IN,
    input wire logic SI_IN,
    output logic SO_OUT,
    output logic SO_OE_OUT,
    input wire logic BUSY_IN,
    input wire logic [7:0] RD_DATA_IN,
    input wire logic RD_VALID_IN,
    output logic EVT_VALID_OUT,
    output evt_t EVT_OUT,
    output logic SELECTED_OUT,
    output logic MODE3_OUT,
    output logic [7:0] STATUS_OUT,
    output logic AUTO_SAVE_EN_OUT
);

    // ---------------- link side: frame state, cleared while deselected
    logic [2:0] bit_cnt_q;
    logic [1:0] addr_cnt_q;
    logic [6:0] shift_q;
    phase_t phase_q;
    logic rise_seen_q;
    logic load_q;
    logic mode3_q;
    logic [7:0] tx_q;
    logic drive_q;

    // ---------------- link side: holding flops read by the system side, then read-answer sync flops and next byte
    cmd_t l_cmd_q;
    cmd_flags_t l_flags_q;
    logic [ADDR_W-1:0] l_addr_q;
    logic [7:0] l_byte_q;
    evt_kind_t l_kind_q;
    logic evt_tgl_q;
    logic rd_meta_q;
    logic rd_sync_q;
    logic rd_seen_q;
    logic [7:0] nxt_byte_q;

    // ---------------- system side
    logic cs_meta_q;
    logic cs_sync_q;
    logic evt_meta_q;
    logic evt_sync_q;
    logic evt_seen_q;
    logic mode_meta_q;
    logic mode_sync_q;
    logic evt_valid_q;
    evt_t evt_q;
    logic [7:0] status_q;
    logic auto_save_q;
    logic [7:0] rd_hold_q;
    logic rd_tgl_q;

    cmd_t dec_cmd;
    cmd_flags_t dec_flags;

    wire [7:0] rx_byte = {shift_q, SI_IN};
    wire byte_done = (bit_cnt_q == LAST_BIT);
    wire take_opc = byte_done && (phase_q == PH_OPCODE);
    wire take_addr = byte_done && (phase_q == PH_ADDR);
    wire take_data = byte_done && (phase_q == PH_DATA);
    wire addr_last = take_addr && (addr_cnt_q == LAST_ADDR_BYTE);
    wire opc_ok = take_opc && dec_flags.valid;

    spi_opcode_decode spi_opcode_decode_i (
        .opcode_in(rx_byte),
        .cmd_out(dec_cmd),
        .flags_out(dec_flags)
    );

    // after the opcode only payload-bearing commands keep listening; the rest,
    // and any unknown code, park in PH_IGNORE until chip select rises
    wire phase_t opc_next =
        !dec_flags.valid ? PH_IGNORE :
        dec_flags.has_addr ? PH_ADDR :
        (dec_flags.reads || dec_flags.writes) ? PH_DATA :
        PH_IGNORE;

    wire phase_t phase_d =
        take_opc ? opc_next :
        addr_last ? PH_DATA :
        phase_q;

    wire [1:0] addr_cnt_d = take_addr ? addr_cnt_q + 2'h1 : addr_cnt_q;

    // a read slot opens at each byte boundary where the next byte goes out
    wire tx_slot = (opc_ok && dec_flags.reads && !dec_flags.has_addr) ||
                   (addr_last && l_flags_q.reads) ||
                   (take_data && l_flags_q.reads);
    wire read_phase = (phase_q == PH_DATA) && l_flags_q.reads;
    wire rd_ready = (rd_sync_q != rd_seen_q);
    wire post_evt = opc_ok || addr_last || take_data;

    // chip select high holds the whole frame in reset, so each falling edge
    // starts from a clean opcode phase
    always_ff @(posedge SCK_IN or posedge CS_N_IN) begin
        if (CS_N_IN) begin
            bit_cnt_q <= BIT_CNT_RESET;
            addr_cnt_q <= FIRST_ADDR_BYTE;
            shift_q <= SHIFT_ZERO;
            phase_q <= PH_OPCODE;
            rise_seen_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            addr_cnt_q <= addr_cnt_d;
            shift_q <= rx_byte[6:0];
            phase_q <= phase_d;
            rise_seen_q <= 1'b1;
            load_q <= tx_slot;
        end
    end

    // mode 3 shows up as a falling edge before the first rising edge;
    // rising-edge sampling then already skips that initial fall
    always_ff @(negedge SCK_IN or posedge CS_N_IN) begin
        if (CS_N_IN) begin
            mode3_q <= 1'b0;
        end else if (!rise_seen_q) begin
            mode3_q <= 1'b1;
        end
    end

    // output shifter runs on falling edges; the master samples on the next rise
    always_ff @(negedge SCK_IN or posedge CS_N_IN) begin
        if (CS_N_IN) begin
            tx_q <= BYTE_ZERO;
            drive_q <= 1'b0;
        end else if (load_q) begin
            tx_q <= nxt_byte_q;
            drive_q <= 1'b1;
        end else if (rise_seen_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // driver is only on while selected and only after a read slot opened;
    // the block never drives without a command from the master
    assign SO_OE_OUT = !CS_N_IN && drive_q;
    assign SO_OUT = tx_q[7];

    // holding flops survive the end of the frame so the last byte still
    // reaches the system side after chip select rises
    always_ff @(posedge SCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            l_cmd_q <= CMD_NONE;
            l_flags_q <= '0;
            l_addr_q <= ADDR_ZERO;
            l_byte_q <= BYTE_ZERO;
            l_kind_q <= EV_OPCODE;
            evt_tgl_q <= 1'b0;
        end else if (!CS_N_IN) begin
            if (take_opc) begin
                l_cmd_q <= dec_cmd;
                l_flags_q <= dec_flags;
                l_kind_q <= EV_OPCODE;
            end
            if (take_addr) begin
                // shifting whole bytes through 17 bits drops the leading seven
                l_addr_q <= {l_addr_q[ADDR_W-BYTE_W-1:0], rx_byte};
                l_kind_q <= EV_ADDR;
            end
            if (take_data) begin
                l_byte_q <= rx_byte;
                l_kind_q <= EV_DATA;
            end
            if (post_evt) begin
                evt_tgl_q <= !evt_tgl_q;
            end
        end
    end

    // read answers cross on a toggle; outside read data phases stale toggles
    // are swallowed so a late answer never leaks into the next frame
    always_ff @(posedge SCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            rd_meta_q <= 1'b0;
            rd_sync_q <= 1'b0;
            rd_seen_q <= 1'b0;
            nxt_byte_q <= BYTE_ZERO;
        end else begin
            rd_meta_q <= rd_tgl_q;
            rd_sync_q <= rd_meta_q;
            if (!CS_N_IN && tx_slot) begin
                nxt_byte_q <= rd_ready ? rd_hold_q : FILL_BYTE;
                rd_seen_q <= rd_sync_q;
            end else if (!read_phase) begin
                rd_seen_q <= rd_sync_q;
            end
        end
    end

    // ---------------- system side
    wire evt_new = (evt_sync_q != evt_seen_q);
    wire evt_t evt_w = '{kind: l_kind_q, cmd: l_cmd_q, addr: l_addr_q, data: l_byte_q};
    wire opc_evt = evt_new && (l_kind_q == EV_OPCODE);
    wire data_evt = evt_new && (l_kind_q == EV_DATA);

    wire set_wen = opc_evt && (l_cmd_q == CMD_WR_ENABLE);
    wire clr_wen = opc_evt && (l_cmd_q == CMD_WR_DISABLE);
    wire wr_status = data_evt && (l_cmd_q == CMD_WR_STATUS);
    wire [7:0] status_wr = (status_q & ~ST_WRITABLE) | (l_byte_q & ST_WRITABLE);
    wire [7:0] status_base = wr_status ? status_wr : status_q;
    wire wen_d = set_wen ? 1'b1 : (clr_wen ? 1'b0 : status_q[ST_WEN]);
    wire [7:0] status_live = {status_q[7:2], status_q[ST_WEN], BUSY_IN};

    // the status byte is answered locally; memory answers come from outside
    wire rd_status = evt_new && (l_cmd_q == CMD_RD_STATUS) && (l_kind_q != EV_ADDR);
    wire rd_take = rd_status || (RD_VALID_IN && (l_cmd_q == CMD_READ));
    wire [7:0] rd_hold_d = rd_status ? status_live : RD_DATA_IN;

    wire auto_save_d = (opc_evt && (l_cmd_q == auto_save_enable_cmd)) ? 1'b1 :
                       (opc_evt && (l_cmd_q == auto_save_disable_cmd)) ? 1'b0 :
                       auto_save_q;

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            evt_meta_q <= 1'b0;
            evt_sync_q <= 1'b0;
            evt_seen_q <= 1'b0;
            mode_meta_q <= 1'b0;
            mode_sync_q <= 1'b0;
        end else begin
            cs_meta_q <= CS_N_IN;
            cs_sync_q <= cs_meta_q;
            evt_meta_q <= evt_tgl_q;
            evt_sync_q <= evt_meta_q;
            evt_seen_q <= evt_sync_q;
            mode_meta_q <= mode3_q;
            mode_sync_q <= mode_meta_q;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            evt_valid_q <= 1'b0;
            evt_q <= '0;
        end else begin
            evt_valid_q <= evt_new;
            if (evt_new) begin
                evt_q <= evt_w;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            status_q <= ST_RESET;
            auto_save_q <= AUTO_SAVE_RESET;
        end else begin
            status_q <= {status_base[7:2], wen_d, BUSY_IN};
            auto_save_q <= auto_save_d;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            rd_hold_q <= BYTE_ZERO;
            rd_tgl_q <= 1'b0;
        end else if (rd_take) begin
            rd_hold_q <= rd_hold_d;
            rd_tgl_q <= !rd_tgl_q;
        end
    end

    assign EVT_VALID_OUT = evt_valid_q;
    assign EVT_OUT = evt_q;
    assign SELECTED_OUT = !cs_sync_q;
    assign MODE3_OUT = mode_sync_q;
    assign STATUS_OUT = status_q;
    assign AUTO_SAVE_EN_OUT = auto_save_q;

endmodule
`default_nettype wire

// file: verilog/spi_front_pkg.sv
// Purpose: shared constants, command codes and carrier types of the serial slave front end
// Assumes: byte-wide memory behind the front end, 17-bit location address
// Notes: link-side and system-side logic both import this package
package spi_front_pkg;

    localparam int BYTE_W = 8;
    localparam int ADDR_W = 17;
    localparam int SCK_MAX_MHZ = 40;

    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
    localparam logic [1:0] FIRST_ADDR_BYTE = 2'h0;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;

    localparam logic [7:0] OPC_WR_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
    localparam logic [7:0] OPC_RD_STATUS = 8'h05;
    localparam logic [7:0] OPC_WR_STATUS = 8'h01;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    localparam logic [7:0] OPC_SAVE = 8'h3C;
    localparam logic [7:0] OPC_RESTORE = 8'h60;
    localparam logic [7:0] OPC_AUTO_SAVE_ON = 8'h59;
    localparam logic [7:0] OPC_AUTO_SAVE_OFF = 8'h19;

    // read slot with no answer from the system side shifts this out
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [6:0] SHIFT_ZERO = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h00000;

    localparam int ST_BUSY = 0;
    localparam int ST_WEN = 1;
    localparam logic [7:0] ST_RESET = 8'h00;
    localparam logic [7:0] ST_WRITABLE = 8'h8C;
    localparam logic AUTO_SAVE_RESET = 1'b1;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_WR_ENABLE = 4'h1,
        CMD_WR_DISABLE = 4'h2,
        CMD_RD_STATUS = 4'h3,
        CMD_WR_STATUS = 4'h4,
        CMD_READ = 4'h5,
        CMD_WRITE = 4'h6,
        CMD_SAVE = 4'h7,
        CMD_RESTORE = 4'h8,
        auto_save_enable_cmd = 4'h9,
        auto_save_disable_cmd = 4'hA
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic has_addr;
        logic reads;
        logic writes;
    } cmd_flags_t;

    typedef enum logic [1:0] {
        PH_OPCODE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b11,
        PH_IGNORE = 2'b10
    } phase_t;

    typedef enum logic [1:0] {
        EV_OPCODE = 2'h0,
        EV_ADDR = 2'h1,
        EV_DATA = 2'h2
    } evt_kind_t;

    typedef struct packed {
        evt_kind_t kind;
        cmd_t cmd;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } evt_t;

endpackage

// file: verilog/spi_opcode_decode.sv
// Purpose: maps a received operation code to a command and its framing flags
// Assumes: purely combinational, evaluated on the completed first byte
// Notes: any code outside the table decodes to CMD_NONE with valid low
`timescale 1ns/1ps
`default_nettype none
module spi_opcode_decode
    import spi_front_pkg::*;
(
    input wire logic [7:0] opcode_in,
    output cmd_t cmd_out,
    output cmd_flags_t flags_out
);

    wire cmd_t cmd_w =
        (opcode_in == OPC_WR_ENABLE) ? CMD_WR_ENABLE :
        (opcode_in == OPC_WR_DISABLE) ? CMD_WR_DISABLE :
        (opcode_in == OPC_RD_STATUS) ? CMD_RD_STATUS :
        (opcode_in == OPC_WR_STATUS) ? CMD_WR_STATUS :
        (opcode_in == OPC_READ) ? CMD_READ :
        (opcode_in == OPC_WRITE) ? CMD_WRITE :
        (opcode_in == OPC_SAVE) ? CMD_SAVE :
        (opcode_in == OPC_RESTORE) ? CMD_RESTORE :
        (opcode_in == OPC_AUTO_SAVE_ON) ? auto_save_enable_cmd :
        (opcode_in == OPC_AUTO_SAVE_OFF) ? auto_save_disable_cmd :
        CMD_NONE;

    assign cmd_out = cmd_w;
    assign flags_out.valid = (cmd_w != CMD_NONE);
    assign flags_out.has_addr = (cmd_w == CMD_READ) || (cmd_w == CMD_WRITE);
    assign flags_out.reads = (cmd_w == CMD_READ) || (cmd_w == CMD_RD_STATUS);
    assign flags_out.writes = (cmd_w == CMD_WRITE) || (cmd_w == CMD_WR_STATUS);

endmodule
`default_nettype wire

// file: verif/spi_slave_front_chk.sv
// Purpose: port-level assertions of the serial slave front end
// Assumes: ports are sampled on CLK_IN; chip select and output enable are asynchronous to it
// Notes: link-side timing is judged by the bench through the master model
`timescale 1ns/1ps
`default_nettype none
module spi_slave_front_chk
    import spi_front_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic CS_N_IN,
    input wire logic BUSY_IN,
    input wire logic SO_OE_OUT,
    input wire logic EVT_VALID_OUT,
    input wire evt_t EVT_OUT,
    input wire logic SELECTED_OUT,
    input wire logic MODE3_OUT,
    input wire logic [7:0] STATUS_OUT,
    input wire logic AUTO_SAVE_EN_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_opc(cmd_t c);
        EVT_VALID_OUT && EVT_OUT.kind == EV_OPCODE && EVT_OUT.cmd == c;
    endsequence

    chk_oe_deselected: assert property (CS_N_IN |-> !SO_OE_OUT)
        else $error("output enabled while deselected");
    chk_evt_pulse: assert property (EVT_VALID_OUT |=> !EVT_VALID_OUT)
        else $error("event strobe longer than one cycle");
    chk_evt_hold: assert property (!EVT_VALID_OUT |-> $stable(EVT_OUT))
        else $error("event changed without strobe");
    chk_sel_rise: assert property ($fell(CS_N_IN) |-> ##[1:4] SELECTED_OUT)
        else $error("selection not reported");
    chk_sel_fall: assert property ($rose(CS_N_IN) |-> ##[1:4] !SELECTED_OUT)
        else $error("deselection not reported");
    chk_mode_clear: assert property ($rose(CS_N_IN) |-> ##[1:4] !MODE3_OUT)
        else $error("mode flag kept after deselection");
    chk_wen_set: assert property (s_opc(CMD_WR_ENABLE) |-> ##[1:2] STATUS_OUT[ST_WEN])
        else $error("write enable not set");
    chk_wen_clear: assert property (s_opc(CMD_WR_DISABLE) |-> ##[1:2] !STATUS_OUT[ST_WEN])
        else $error("write enable not cleared");
    chk_auto_off: assert property (s_opc(auto_save_disable_cmd) |-> ##[1:2] !AUTO_SAVE_EN_OUT)
        else $error("auto save not disabled");
    chk_auto_on: assert property (s_opc(auto_save_enable_cmd) |-> ##[1:2] AUTO_SAVE_EN_OUT)
        else $error("auto save not enabled");
    chk_bad_code: assert property (EVT_VALID_OUT && EVT_OUT.kind == EV_OPCODE |-> EVT_OUT.cmd != CMD_NONE)
        else $error("unknown code reported");
    chk_busy_bit: assert property (!$past(RESET_IN) |-> STATUS_OUT[ST_BUSY] == $past(BUSY_IN))
        else $error("busy bit does not follow input");
endmodule
bind spi_slave_front spi_slave_front_chk spi_slave_front_chk_i (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
    .CS_N_IN(CS_N_IN), .BUSY_IN(BUSY_IN), .SO_OE_OUT(SO_OE_OUT), .EVT_VALID_OUT(EVT_VALID_OUT),
    .EVT_OUT(EVT_OUT), .SELECTED_OUT(SELECTED_OUT), .MODE3_OUT(MODE3_OUT), .STATUS_OUT(STATUS_OUT),
    .AUTO_SAVE_EN_OUT(AUTO_SAVE_EN_OUT));
`default_nettype wire

// file: verif/spi_master_model.sv
// Purpose: behavioural serial bus master facing the slave front end
// Assumes: 8 MHz serial clock, mode chosen per frame
// Notes: clock parks at the mode's idle level between frames
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    output var logic sck_out,
    output var logic cs_n_out,
    output var logic si_out,
    input wire logic so_in
);
    localparam realtime HALF = 62.5;
    logic idle_hi = 1'b0;
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    task automatic start(input logic m3);
        idle_hi = m3;
        sck_out = m3;
        #(HALF);
        cs_n_out = 1'b0;
        #(HALF);
    endtask
    // bit set up on the fall, sampled on the rise, msb first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_out = 1'b0;
            si_out = tx[i];
            #(HALF);
            sck_out = 1'b1;
            rx[i] = so_in;
            #(HALF);
        end
    endtask
    task automatic stop();
        #(HALF);
        sck_out = idle_hi;
        #(HALF);
        cs_n_out = 1'b1;
        si_out = ~si_out;
        #(4 * HALF);
    endtask
    // traffic meant for another slave while this one is not selected
    task automatic wiggle();
        repeat (8) begin
            sck_out = ~sck_out;
            si_out = ~si_out;
            #(HALF);
        end
        sck_out = idle_hi;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_spi_slave_front.sv
// Purpose: self-checking bench of the serial slave front end
// Assumes: master model on the link, bench answers read events
// Notes: memory answer is a fixed function of the address
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_front
    import spi_front_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic busy = 1'b0;
    logic rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00;
    wire logic sck, cs_n, si, so, so_oe, evt_valid, selected, mode3, auto_en;
    wire logic so_line = so_oe ? so : 1'bz;
    evt_t evt;
    logic [7:0] status;
    logic [7:0] rxb [6];
    evt_t evq [$];
    int err_total = 0;
    int checked = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    spi_slave_front spi_slave_front_i (.CLK_IN(clk), .RESET_IN(rst), .SCK_IN(sck), .CS_N_IN(cs_n),
        .SI_IN(si), .SO_OUT(so), .SO_OE_OUT(so_oe), .BUSY_IN(busy), .RD_DATA_IN(rd_data),
        .RD_VALID_IN(rd_valid), .EVT_VALID_OUT(evt_valid), .EVT_OUT(evt), .SELECTED_OUT(selected),
        .MODE3_OUT(mode3), .STATUS_OUT(status), .AUTO_SAVE_EN_OUT(auto_en));
    spi_master_model spi_master_model_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so_line));

    function automatic logic [7:0] mem_of(input logic [16:0] a);
        return a[7:0] ^ a[15:8];
    endfunction

    always @(posedge clk) begin
        if (evt_valid === 1'b1) begin
            evq.push_back(evt);
        end
    end

    // one answer per read event, given half a cycle after the strobe
    always @(negedge clk) begin
        rd_valid <= evt_valid === 1'b1 && evt.cmd === CMD_READ && evt.kind !== EV_OPCODE;
        rd_data <= mem_of(evt.addr);
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic m3, input int n, input logic [47:0] tx);
        evq.delete();
        spi_master_model_i.start(m3);
        for (int i = 0; i < n; i++) begin
            spi_master_model_i.xfer(tx[47 - 8 * i -: 8], rxb[i]);
        end
        check(mode3, m3);
        spi_master_model_i.stop();
    endtask

    task automatic t_reset();
        check({status, auto_en, so_oe, selected, evt_valid}, {ST_RESET, 4'h8});
    endtask

    task automatic t_opcodes();
        logic [7:0] codes [10] = '{OPC_WR_ENABLE, OPC_WR_DISABLE, OPC_RD_STATUS, OPC_WR_STATUS,
            OPC_READ, OPC_WRITE, OPC_SAVE, OPC_RESTORE, OPC_AUTO_SAVE_OFF, OPC_AUTO_SAVE_ON};
        cmd_t cmds [10] = '{CMD_WR_ENABLE, CMD_WR_DISABLE, CMD_RD_STATUS, CMD_WR_STATUS, CMD_READ,
            CMD_WRITE, CMD_SAVE, CMD_RESTORE, auto_save_disable_cmd, auto_save_enable_cmd};
        for (int i = 0; i < 10; i++) begin
            frame(i[0], 1, {codes[i], 40'h0});
            check(evq.size(), 1);
            check({evq[0].kind, evq[0].cmd}, {EV_OPCODE, cmds[i]});
            if (i >= 8) begin
                check(auto_en, i == 9);
            end
        end
    endtask

    task automatic t_status();
        @(negedge clk);
        busy = 1'b1;
        frame(1'b0, 2, {OPC_WR_ENABLE, OPC_WR_DISABLE, 32'h0});
        check(status, 8'h03);
        frame(1'b1, 2, {OPC_WR_STATUS, 8'hFF, 32'h0});
        check(status, ST_WRITABLE | 8'h03);
        frame(1'b0, 3, {OPC_RD_STATUS, 40'h0});
        check({rxb[1], rxb[2]}, {FILL_BYTE, ST_WRITABLE | 8'h03});
        @(negedge clk);
        busy = 1'b0;
    endtask

    task automatic t_read();
        frame(1'b1, 6, {OPC_READ, 24'h00DCBA, 16'h0});
        check({evq[1].kind, evq[1].addr}, {EV_ADDR, 17'h0DCBA});
        check({rxb[0], rxb[4], rxb[5]}, {8'hZZ, FILL_BYTE, mem_of(17'h0DCBA)});
    endtask

    task automatic t_write();
        frame(1'b0, 5, {OPC_WRITE, 24'hFF2345, 8'hA7, 8'h00});
        check(evq.size(), 3);
        check({evq[1].kind, evq[1].addr, evq[2].kind, evq[2].data}, {EV_ADDR, 17'h12345, EV_DATA, 8'hA7});
        check(rxb[4], 8'hZZ);
    endtask

    task automatic t_quiet();
        frame(1'b0, 4, {8'h1E, OPC_READ, 32'h0});
        check({evq.size() == 0, rxb[3]}, {1'b1, 8'hZZ});
        evq.delete();
        spi_master_model_i.wiggle();
        repeat (20) @(negedge clk);
        check({evq.size() == 0, selected}, 2'b10);
        frame(1'b1, 1, {OPC_SAVE, 40'h0});
        check({evq[0].kind, evq[0].cmd}, {EV_OPCODE, CMD_SAVE});
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (checked > 0 && err_total == 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #500us;
        err_total++;
        final_report();
    end

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        $display("reset test done");
        t_opcodes();
        $display("opcode test done");
        t_status();
        $display("status test done");
        t_read();
        $display("read test done");
        t_write();
        $display("write test done");
        t_quiet();
        $display("quiet test done");
        final_report();
    end
endmodule
`default_nettype wire
